//--- hdl/flash_map.svh
// constants for the serial NOR array map, security regions and discovery table
// assumes inclusion by flash_pkg and the design modules; definitions only
// Summary of operation
// - Main array decodes as 32 blocks of 64 KB and 512 sectors of 4 KB.
// - Program pages are 256 bytes, 8192 pages, each programmed on its own.
// - Programming only clears bits; only an erase sets bits back to one.
// - Erase works on sector, block or whole chip; there is no page erase.
// - A sector spans low twelve address bits; sector index is address above bit 11.
// - Four separate 256-byte security regions sit outside the main array.
// - One-time lock bits in status register two protect regions; cleared only by reset.
// - User regions 1 to 3 each erase, program and lock independently.
// - Opcode 5Ah reads the discovery parameter space, apart from the array.
// - Discovery space is factory content and read-only; host writes change nothing.
// - Discovery header starts at byte zero of that space.
// - First parameter table starts at byte 0030h.
// - Bytes from 0020h up to the table are undefined and reserved.
// - Bytes 0 to 3 return 53h, 46h, 44h, 50h in order.
// - Byte 04h returns minor revision 08h.
// - Byte 05h returns major revision 01h.
// - Byte 06h returns zero-based header count, programmed as 01h.
// - Byte 07h, the access protocol field, returns FFh.
// - Byte 08h returns 00h, the basic table identifier low byte.
// - Byte 09h returns 07h, basic table minor revision.
// - Byte 0Bh returns table length 10h, sixteen double words.
// - Bytes 0Ch to 0Eh point to the table: 30h, 00h, 00h.
`ifndef FLASH_MAP_SVH
`define FLASH_MAP_SVH

// ================================================================
// geometry
`define ARRAY_AW 21
`define SECTOR_AW 12
`define BLOCK_AW 16
`define SECTOR_BYTES 24'h001000
`define BLOCK_BYTES 24'h010000
`define CHIP_BYTES 24'h200000
`define SECREG_BYTES 24'h000100

// ================================================================
// opcodes
`define OPC_READ 8'h03
`define OPC_PROG 8'h02
`define OPC_SECTOR_ERASE 8'h20
`define OPC_BLOCK_ERASE 8'hD8
`define OPC_CHIP_ERASE 8'hC7
`define OPC_CHIP_ERASE_ALT 8'h60
`define OPC_WREN 8'h06
`define OPC_WRDI 8'h04
`define OPC_RDSR1 8'h05
`define OPC_RDSR2 8'h35
`define OPC_WRSR2 8'h31
`define OPC_SEC_ERASE 8'h44
`define OPC_SEC_PROG 8'h42
`define OPC_SEC_READ 8'h48
`define READ_DISCOVERY_PARAMS_CMD 8'h5A

// ================================================================
// discovery table bytes
`define DISC_SIG0 8'h53
`define DISC_SIG1 8'h46
`define DISC_SIG2 8'h44
`define DISC_SIG3 8'h50
`define DISC_MINOR 8'h08
`define DISC_MAJOR 8'h01
`define DISC_NHDR 8'h01
`define DISC_ACCESS 8'hFF
`define DISC_ID_LSB 8'h00
`define DISC_TBL_MINOR 8'h07
`define DISC_TBL_MAJOR 8'h01
`define DISC_TBL_LEN 8'h10
`define DISC_TBL_BASE 8'h30
`define DISC_ID_MSB 8'hFF
`define DISC_RSVD_BASE 8'h20
`define DISC_UNDEF 8'hFF
`define DISC_ZERO 8'h00

`endif

//--- hdl/flash_pkg.sv
// types shared by the flash map device modules
// assumes flash_map.svh for widths
`default_nettype none
`include "flash_map.svh"

package flash_pkg;

  // ================================================================
  // enumerations
  typedef enum logic [2:0] {
    PH_CMD = 3'b000, PH_ADDR = 3'b001, PH_DUMMY = 3'b010, PH_READ = 3'b011,
    PH_PROG = 3'b100, PH_WSR = 3'b101, PH_IGNORE = 3'b110
  } phase_t;

  typedef enum logic [2:0] {
    SRC_ARRAY = 3'b000, SRC_SEC = 3'b001, SRC_DISC = 3'b010,
    SRC_STATUS1 = 3'b011, SRC_STATUS2 = 3'b100
  } src_t;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000, OP_PROG = 3'b001, OP_PSEC = 3'b010, OP_SECTOR = 3'b011,
    OP_BLOCK = 3'b100, OP_CHIP = 3'b101, OP_ESEC = 3'b110, OP_LOCK = 3'b111
  } op_t;

  typedef enum logic [0:0] {ENG_IDLE = 1'b0, ENG_ERASE = 1'b1} engine_t;

  // ================================================================
  // carriers
  typedef struct packed {
    logic sclk;
    logic csN;
    logic mosi;
  } spi_in_t;

  typedef struct packed {
    logic [2:0] sSclk;
    logic [1:0] sCs;
    logic [1:0] sMosi;
    phase_t phase;
    src_t src;
    op_t op;
    engine_t eng;
    logic [7:0] shIn;
    logic [2:0] bitCnt;
    logic [1:0] addrLeft;
    logic [23:0] addr;
    logic dummy;
    logic [7:0] rdData;
    logic [7:0] shOut;
    logic miso;
    logic misoOeN;
    logic wel;
    logic [2:0] lock;
    logic armed;
    logic [23:0] erAddr;
    logic [23:0] erLeft;
    logic erSec;
    logic busy;
  } state_t;

endpackage : flash_pkg

`default_nettype wire

//--- hdl/disc_rom.sv
// read-only discovery parameter space, one registered byte per address
// assumes a same-clock address from the flash map core
`timescale 1ns/1ps
`default_nettype none
`include "flash_map.svh"

module disc_rom (
  input wire logic clk,
  input wire logic [7:0] addr,
  output logic [7:0] data
);

  typedef struct packed {
    logic [7:0] data;
  } rom_state_t;

  rom_state_t r;
  rom_state_t n;

  // ================================================================
  // table lookup; there is no write path at all
  always_comb
  begin
    n = r;
    case (addr)
      8'h00: n.data = `DISC_SIG0; // header at byte zero
      8'h01: n.data = `DISC_SIG1;
      8'h02: n.data = `DISC_SIG2;
      8'h03: n.data = `DISC_SIG3;
      8'h04: n.data = `DISC_MINOR;
      8'h05: n.data = `DISC_MAJOR;
      8'h06: n.data = `DISC_NHDR;
      8'h07: n.data = `DISC_ACCESS;
      8'h08: n.data = `DISC_ID_LSB;
      8'h09: n.data = `DISC_TBL_MINOR;
      8'h0A: n.data = `DISC_TBL_MAJOR;
      8'h0B: n.data = `DISC_TBL_LEN;
      8'h0C: n.data = `DISC_TBL_BASE;
      8'h0D: n.data = `DISC_ZERO;
      8'h0E: n.data = `DISC_ZERO;
      8'h0F: n.data = `DISC_ID_MSB;
      // reserved header extension and table body read as erased
      default: n.data = `DISC_UNDEF;
    endcase
  end

  always_ff @(posedge clk)
  begin
    r <= n;
  end

  assign data = r.data;

endmodule : disc_rom

`default_nettype wire

//--- hdl/flash_array_map.sv
// serial NOR device core: array map, security regions, discovery reads
// assumes SPI mode 0 from the host with sclk at most clk/10, pins async
`timescale 1ns/1ps
`default_nettype none
`include "flash_map.svh"

module flash_array_map #(
  parameter int ADDR_W = `ARRAY_AW
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire flash_pkg::spi_in_t spiIn,
  output logic miso,
  output logic misoOeN,
  output logic busy
);

  localparam int ARRAY_BYTES = 1 << ADDR_W;
  localparam int SEC_BYTES = 1024;

  localparam flash_pkg::state_t ST_RESET = '{
    sSclk: 3'b000,
    sCs: 2'b11,
    sMosi: 2'b00,
    phase: flash_pkg::PH_CMD,
    src: flash_pkg::SRC_ARRAY,
    op: flash_pkg::OP_NONE,
    eng: flash_pkg::ENG_IDLE,
    misoOeN: 1'b1,
    default: '0
  };

  // ================================================================
  // storage
  logic [7:0] mem [ARRAY_BYTES];
  logic [7:0] sec [SEC_BYTES];

  flash_pkg::state_t r;
  flash_pkg::state_t n;

  logic arrWe;
  logic secWe;
  logic wrFill;
  logic [7:0] wrByte;
  logic [ADDR_W-1:0] arrWa;
  logic [9:0] secWa;
  logic [7:0] memRd;
  logic [7:0] secRd;
  logic [7:0] discRd;
  logic rise;
  logic fall;
  logic [7:0] b;
  logic [23:0] nAddr;

  // region 0 holds discovery data and is never writable; locks cover 1 to 3
  function automatic logic secWritable(
    input logic [2:0] lock,
    input logic [1:0] region
  );
    logic ok;
    ok = 1'b0;
    case (region)
      2'd1: ok = ~lock[0];
      2'd2: ok = ~lock[1];
      2'd3: ok = ~lock[2];
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : secWritable

  // ================================================================
  // read paths
  assign memRd = mem[r.addr[ADDR_W-1:0]];
  assign secRd = sec[{r.addr[13:12], r.addr[7:0]}];

  disc_rom u_disc_rom (
    .clk(clk),
    .addr(r.addr[7:0]),
    .data(discRd)
  );

  // ================================================================
  // next state
  always_comb
  begin
    n = r;
    arrWe = 1'b0;
    secWe = 1'b0;
    wrFill = 1'b0;
    wrByte = 8'hFF;
    arrWa = '0;
    secWa = '0;
    b = {r.shIn[6:0], r.sMosi[1]};
    nAddr = {r.addr[15:0], b};

    // pins pass two flops, sclk three; cs and mosi use the second stage, sclk edges compare the second and third
    n.sSclk = {r.sSclk[1:0], spiIn.sclk};
    n.sCs = {r.sCs[0], spiIn.csN};
    n.sMosi = {r.sMosi[0], spiIn.mosi};
    rise = r.sSclk[1] & ~r.sSclk[2];
    fall = ~r.sSclk[1] & r.sSclk[2];

    // byte presented on the next byte boundary of a read
    case (r.src)
      flash_pkg::SRC_ARRAY: n.rdData = memRd;
      flash_pkg::SRC_SEC: n.rdData = (r.addr[13:12] == 2'd0) ? discRd : secRd;
      flash_pkg::SRC_DISC: n.rdData = discRd;
      flash_pkg::SRC_STATUS1: n.rdData = {6'h00, r.wel, r.busy};
      flash_pkg::SRC_STATUS2: n.rdData = {2'b00, r.lock, 3'b000};
      default: n.rdData = 8'hFF;
    endcase

    // ================================================================
    // erase engine: one byte per clock, so block and chip erase take
    // 64 Ki and 2 Mi cycles; all reads except status reads, and all writes, are refused meanwhile
    if (r.eng == flash_pkg::ENG_ERASE)
    begin
      wrFill = 1'b1;
      if (r.erSec)
      begin
        secWe = 1'b1;
        secWa = r.erAddr[9:0];
      end
      else
      begin
        arrWe = 1'b1;
        arrWa = r.erAddr[ADDR_W-1:0];
      end
      n.erAddr = r.erAddr + 24'h000001;
      n.erLeft = r.erLeft - 24'h000001;
      if (r.erLeft == 24'h000001)
      begin
        n.eng = flash_pkg::ENG_IDLE;
      end
    end

    // ================================================================
    // frame handling
    if (r.sCs[1])
    begin
      n.phase = flash_pkg::PH_CMD;
      n.bitCnt = 3'd0;
      n.misoOeN = 1'b1;
      n.miso = 1'b0;
      // accepted writes end the write enable and launch erases at deselect
      if (r.armed)
      begin
        n.armed = 1'b0;
        n.wel = 1'b0;
        n.erSec = 1'b0;
        case (r.op)
          flash_pkg::OP_SECTOR:
          begin
            n.erAddr = {r.addr[23:`SECTOR_AW], 12'h000};
            n.erLeft = `SECTOR_BYTES;
            n.eng = flash_pkg::ENG_ERASE;
          end
          flash_pkg::OP_BLOCK:
          begin
            n.erAddr = {r.addr[23:`BLOCK_AW], 16'h0000};
            n.erLeft = `BLOCK_BYTES;
            n.eng = flash_pkg::ENG_ERASE;
          end
          flash_pkg::OP_CHIP:
          begin
            n.erAddr = 24'h000000;
            n.erLeft = `CHIP_BYTES;
            n.eng = flash_pkg::ENG_ERASE;
          end
          flash_pkg::OP_ESEC:
          begin
            n.erAddr = {14'h0000, r.addr[13:12], 8'h00};
            n.erLeft = `SECREG_BYTES;
            n.erSec = 1'b1;
            n.eng = flash_pkg::ENG_ERASE;
          end
          default: ;
        endcase
      end
    end
    else
    begin
      if (rise)
      begin
        n.shIn = b;
        n.bitCnt = r.bitCnt + 3'd1;
        if (r.bitCnt == 3'd7)
        begin
          case (r.phase)
            flash_pkg::PH_CMD:
            begin
              n.phase = flash_pkg::PH_IGNORE;
              n.op = flash_pkg::OP_NONE;
              n.addrLeft = 2'd2;
              n.dummy = 1'b0;
              // while busy only status reads are honoured
              if (!r.busy || b == `OPC_RDSR1 || b == `OPC_RDSR2)
              begin
                case (b)
                  `OPC_READ:
                  begin
                    n.src = flash_pkg::SRC_ARRAY;
                    n.phase = flash_pkg::PH_ADDR;
                  end
                  `READ_DISCOVERY_PARAMS_CMD:
                  begin
                    n.src = flash_pkg::SRC_DISC;
                    n.dummy = 1'b1;
                    n.phase = flash_pkg::PH_ADDR;
                  end
                  `OPC_SEC_READ:
                  begin
                    n.src = flash_pkg::SRC_SEC;
                    n.dummy = 1'b1;
                    n.phase = flash_pkg::PH_ADDR;
                  end
                  `OPC_RDSR1:
                  begin
                    n.src = flash_pkg::SRC_STATUS1;
                    n.phase = flash_pkg::PH_READ;
                  end
                  `OPC_RDSR2:
                  begin
                    n.src = flash_pkg::SRC_STATUS2;
                    n.phase = flash_pkg::PH_READ;
                  end
                  `OPC_WREN: n.wel = 1'b1;
                  `OPC_WRDI: n.wel = 1'b0;
                  `OPC_PROG:
                  begin
                    n.op = flash_pkg::OP_PROG;
                    n.phase = flash_pkg::PH_ADDR;
                  end
                  `OPC_SEC_PROG:
                  begin
                    n.op = flash_pkg::OP_PSEC;
                    n.phase = flash_pkg::PH_ADDR;
                  end
                  `OPC_SECTOR_ERASE:
                  begin
                    n.op = flash_pkg::OP_SECTOR;
                    n.phase = flash_pkg::PH_ADDR;
                  end
                  `OPC_BLOCK_ERASE:
                  begin
                    n.op = flash_pkg::OP_BLOCK;
                    n.phase = flash_pkg::PH_ADDR;
                  end
                  `OPC_SEC_ERASE:
                  begin
                    n.op = flash_pkg::OP_ESEC;
                    n.phase = flash_pkg::PH_ADDR;
                  end
                  `OPC_CHIP_ERASE, `OPC_CHIP_ERASE_ALT:
                  begin
                    n.op = flash_pkg::OP_CHIP;
                    n.armed = r.wel;
                  end
                  `OPC_WRSR2:
                  begin
                    n.op = flash_pkg::OP_LOCK;
                    n.phase = flash_pkg::PH_WSR;
                  end
                  default: ;
                endcase
              end
            end
            flash_pkg::PH_ADDR:
            begin
              n.addr = nAddr;
              n.addrLeft = r.addrLeft - 2'd1;
              if (r.addrLeft == 2'd0)
              begin
                n.phase = flash_pkg::PH_IGNORE;
                case (r.op)
                  flash_pkg::OP_NONE:
                    n.phase = r.dummy ? flash_pkg::PH_DUMMY : flash_pkg::PH_READ;
                  flash_pkg::OP_PROG:
                  begin
                    if (r.wel)
                    begin
                      n.phase = flash_pkg::PH_PROG;
                      n.armed = 1'b1;
                    end
                  end
                  flash_pkg::OP_PSEC:
                  begin
                    if (r.wel && secWritable(r.lock, nAddr[13:12]))
                    begin
                      n.phase = flash_pkg::PH_PROG;
                      n.armed = 1'b1;
                    end
                  end
                  flash_pkg::OP_ESEC:
                    n.armed = r.wel && secWritable(r.lock, nAddr[13:12]);
                  flash_pkg::OP_SECTOR, flash_pkg::OP_BLOCK:
                    n.armed = r.wel;
                  default: ;
                endcase
              end
            end
            flash_pkg::PH_DUMMY: n.phase = flash_pkg::PH_READ;
            flash_pkg::PH_READ:
            begin
              // array reads roll over the whole space, regions within 256 bytes
              if (r.src == flash_pkg::SRC_ARRAY)
              begin
                n.addr[ADDR_W-1:0] = r.addr[ADDR_W-1:0] + 1'b1;
              end
              else
              begin
                n.addr[7:0] = r.addr[7:0] + 8'h01;
              end
            end
            flash_pkg::PH_PROG:
            begin
              wrByte = b;
              if (r.op == flash_pkg::OP_PROG)
              begin
                arrWe = 1'b1;
                arrWa = r.addr[ADDR_W-1:0];
              end
              else
              begin
                secWe = 1'b1;
                secWa = {r.addr[13:12], r.addr[7:0]};
              end
              n.addr[7:0] = r.addr[7:0] + 8'h01; // wraps inside the page
            end
            flash_pkg::PH_WSR:
            begin
              if (r.wel)
              begin
                n.lock = r.lock | b[5:3]; // set only; only reset clears them
                n.armed = 1'b1;
              end
              n.phase = flash_pkg::PH_IGNORE;
            end
            default: ;
          endcase
        end
      end
      // data leaves on the falling edge so the host samples on the rising one
      if (fall && r.phase == flash_pkg::PH_READ)
      begin
        n.misoOeN = 1'b0;
        if (r.bitCnt == 3'd0)
        begin
          n.miso = r.rdData[7];
          n.shOut = {r.rdData[6:0], 1'b0};
        end
        else
        begin
          n.miso = r.shOut[7];
          n.shOut = {r.shOut[6:0], 1'b0};
        end
      end
    end

    n.busy = (n.eng == flash_pkg::ENG_ERASE);
  end

  // ================================================================
  // registers
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      r <= ST_RESET;
    end
    else
    begin
      r <= n;
    end
  end

  // programming ANDs with the old byte so ones can only become zeros;
  // a plain clocked process, since the erased image is also set at time zero
  always @(posedge clk)
  begin
    if (arrWe)
    begin
      mem[arrWa] <= wrFill ? 8'hFF : (mem[arrWa] & wrByte);
    end
    if (secWe)
    begin
      sec[secWa] <= wrFill ? 8'hFF : (sec[secWa] & wrByte);
    end
  end

  // contents start erased; there is no reset for the storage itself
  initial
  begin
    for (int i = 0; i < ARRAY_BYTES; i++)
    begin
      mem[i] = 8'hFF;
    end
    for (int j = 0; j < SEC_BYTES; j++)
    begin
      sec[j] = 8'hFF;
    end
  end

  assign miso = r.miso;
  assign misoOeN = r.misoOeN;
  assign busy = r.busy;

endmodule : flash_array_map

`default_nettype wire

//--- dv/flash_map_monitor.sv
// pin-level checks for the flash map device
// assumes a bind to flash_array_map with one clock and synchronous reset
`timescale 1ns/1ps
`default_nettype none

module flash_map_monitor #(
  parameter int ADDR_W = 21
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire flash_pkg::spi_in_t spiIn,
  input wire logic miso,
  input wire logic misoOeN,
  input wire logic busy
);
  logic [9:0] csLowCnt;
  logic [21:0] busyLen;

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  // ================================================================
  // helper counters
  // saturating so a long frame cannot wrap back under the threshold
  always_ff @(posedge clk)
  begin
    if (!reset_n || spiIn.csN)
      csLowCnt <= 10'h000;
    else if (csLowCnt != 10'h3FF)
      csLowCnt <= csLowCnt + 10'h001;
    if (!reset_n || !busy)
      busyLen <= 22'h000000;
    else
      busyLen <= busyLen + 22'h000001;
  end

  // ================================================================
  // assertions
  a_miso_idle_low: assert property (misoOeN |-> !miso)
    else $error("miso not low while output disabled");
  a_oe_release: assert property (spiIn.csN [*5] |-> misoOeN)
    else $error("output still enabled after deselect");
  a_oe_first_fall: assert property ($fell(misoOeN) |-> !spiIn.csN && !spiIn.sclk)
    else $error("output enabled outside a low serial clock");
  a_oe_after_cmd: assert property ($fell(misoOeN) |-> csLowCnt >= 10'h03C)
    else $error("output enabled before a command was shifted in");
  a_miso_on_fall: assert property (!misoOeN && $changed(miso) |-> !spiIn.sclk)
    else $error("read data changed while serial clock high");
  a_busy_after_cs: assert property ($rose(busy) |-> spiIn.csN && $past(spiIn.csN, 2))
    else $error("erase started without a deselect");
  a_busy_min_run: assert property ($rose(busy) |-> busy [*8])
    else $error("erase busy pulse too short");
  a_busy_exact_len: assert property ($fell(busy) |-> busyLen inside
    {[22'h000100:22'h000101], [22'h001000:22'h001001], [22'h010000:22'h010001],
    [22'h200000:22'h200001]})
    else $error("erase length matches no erase size");
endmodule : flash_map_monitor

bind flash_array_map flash_map_monitor #(.ADDR_W(ADDR_W)) flash_map_monitor_i (
  .clk(clk),
  .reset_n(reset_n),
  .spiIn(spiIn),
  .miso(miso),
  .misoOeN(misoOeN),
  .busy(busy)
);

`default_nettype wire

//--- dv/spi_host_model.sv
// mode 0 serial host that frames commands for the flash map device
// assumes the bench calls its tasks; half sets the serial clock speed
`timescale 1ns/1ps
`default_nettype none

module spi_host_model (
  input wire logic clk,
  input wire logic miso,
  input wire logic misoOeN,
  output var flash_pkg::spi_in_t spiOut
);
  int half = 6;

  initial spiOut = '{sclk: 1'b0, csN: 1'b1, mosi: 1'b0};

  // ================================================================
  // frame tasks
  task automatic open_frame();
    @(posedge clk);
    spiOut.csN <= 1'b0;
    repeat (half) @(posedge clk);
  endtask : open_frame

  // a bit read while the output is disabled comes back unknown
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      spiOut.mosi <= tx[i];
      repeat (half) @(posedge clk);
      spiOut.sclk <= 1'b1;
      rx[i] = misoOeN ? 1'bx : miso;
      repeat (half) @(posedge clk);
      spiOut.sclk <= 1'b0;
    end
  endtask : xfer

  // mosi flips when released so a stale level never looks valid
  task automatic close_frame();
    repeat (half) @(posedge clk);
    spiOut.csN <= 1'b1;
    spiOut.mosi <= ~spiOut.mosi;
    repeat (8) @(posedge clk);
  endtask : close_frame
endmodule : spi_host_model

`default_nettype wire

//--- dv/testbench.sv
// self-checking bench for the flash map device
// assumes the serial host model and the bound pin monitor
`timescale 1ns/1ps
`default_nettype none
`include "flash_map.svh"

module testbench;
  logic clk = 1'b0;
  logic resetN;
  flash_pkg::spi_in_t spiIn;
  logic miso;
  logic misoOeN;
  logic busy;
  int nMismatch = 0;
  int totalChecks = 0;
  int cycles = 0;

  always #50 clk = ~clk;

  flash_array_map flash_array_map_i (.clk(clk), .reset_n(resetN), .spiIn(spiIn),
    .miso(miso), .misoOeN(misoOeN), .busy(busy));
  spi_host_model spi_host_model_i (.clk(clk), .miso(miso), .misoOeN(misoOeN),
    .spiOut(spiIn));

  // ================================================================
  // shared tasks
  task automatic closeOut();
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : closeOut

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic hdr(input logic [7:0] op, input logic [23:0] a);
    logic [7:0] d;
    spi_host_model_i.open_frame();
    spi_host_model_i.xfer(op, d);
    for (int i = 2; i >= 0; i--)
      spi_host_model_i.xfer(a[i*8 +: 8], d);
  endtask : hdr

  task automatic cmd2(input logic [7:0] op, input logic [7:0] v, output logic [7:0] d);
    spi_host_model_i.open_frame();
    spi_host_model_i.xfer(op, d);
    spi_host_model_i.xfer(v, d);
    spi_host_model_i.close_frame();
  endtask : cmd2

  task automatic wren();
    logic [7:0] d;
    spi_host_model_i.open_frame();
    spi_host_model_i.xfer(8'h06, d);
    spi_host_model_i.close_frame();
  endtask : wren

  task automatic write1(input logic [7:0] op, input logic [23:0] a, input logic [7:0] v);
    logic [7:0] d;
    wren();
    hdr(op, a);
    spi_host_model_i.xfer(v, d);
    spi_host_model_i.close_frame();
  endtask : write1

  task automatic read1(input logic [7:0] op, input logic [23:0] a, output logic [7:0] v);
    logic [7:0] d;
    hdr(op, a);
    if (op != 8'h03)
      spi_host_model_i.xfer(8'h00, d);
    spi_host_model_i.xfer(8'h00, v);
    spi_host_model_i.close_frame();
  endtask : read1

  task automatic erase(input logic [7:0] op, input logic [23:0] a, input int len);
    logic [7:0] d;
    int n = 0;
    wren();
    hdr(op, a);
    spi_host_model_i.close_frame();
    chk("busyStart", {7'h00, busy}, 8'h01);
    cmd2(8'h05, 8'h00, d);
    chk("statusBusy", d, 8'h01);
    while (busy === 1'b1 && n < len + 100)
    begin
      @(posedge clk);
      n++;
    end
    chk("busyEnd", {7'h00, busy}, 8'h00);
  endtask : erase

  // ================================================================
  // scenarios
  // slow clock, whole header streamed in one frame
  task automatic t_header();
    logic [7:0] d;
    logic [7:0] exp [16] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h08, 8'h01, 8'h01, 8'hFF,
      8'h00, 8'h07, 8'h01, 8'h10, 8'h30, 8'h00, 8'h00, 8'hFF};
    spi_host_model_i.half = 10;
    hdr(`READ_DISCOVERY_PARAMS_CMD, 24'h000000);
    spi_host_model_i.xfer(8'h00, d);
    for (int i = 0; i < 16; i++)
    begin
      spi_host_model_i.xfer(8'h00, d);
      chk("discByte", d, exp[i]);
    end
    spi_host_model_i.close_frame();
    spi_host_model_i.half = 6;
    read1(8'h5A, 24'h00000C, d);
    chk("tablePtr", d, 8'h30);
    read1(8'h5A, 24'h00000B, d);
    chk("tableLen", d, 8'h10);
  endtask : t_header

  task automatic t_readonly();
    logic [7:0] d;
    write1(8'h42, 24'h000000, 8'h00);
    read1(8'h5A, 24'h000000, d);
    chk("discAfterWrite", d, 8'h53);
  endtask : t_readonly

  // two bytes from the page end: the second wraps to the page start
  task automatic t_program();
    logic [7:0] d;
    wren();
    hdr(8'h02, 24'h0100FF);
    spi_host_model_i.xfer(8'hA5, d);
    spi_host_model_i.xfer(8'h3C, d);
    spi_host_model_i.close_frame();
    read1(8'h03, 24'h0100FF, d);
    chk("pageEnd", d, 8'hA5);
    read1(8'h03, 24'h010000, d);
    chk("pageWrap", d, 8'h3C);
    read1(8'h03, 24'h010100, d);
    chk("nextPage", d, 8'hFF);
    write1(8'h02, 24'h0100FF, 8'h5A);
    read1(8'h03, 24'h0100FF, d);
    chk("andProgram", d, 8'h00);
  endtask : t_program

  task automatic t_sector();
    logic [7:0] d;
    write1(8'h02, 24'h002FFF, 8'h00);
    write1(8'h02, 24'h003000, 8'h00);
    erase(8'h20, 24'h002123, 4096);
    read1(8'h03, 24'h002FFF, d);
    chk("sectorTop", d, 8'hFF);
    read1(8'h03, 24'h003000, d);
    chk("nextSector", d, 8'h00);
  endtask : t_sector

  task automatic t_secreg();
    logic [7:0] d;
    write1(8'h42, 24'h001010, 8'h12);
    write1(8'h42, 24'h002010, 8'h34);
    read1(8'h48, 24'h001010, d);
    chk("region1", d, 8'h12);
    read1(8'h03, 24'h001010, d);
    chk("arrayApart", d, 8'hFF);
    wren();
    cmd2(8'h31, 8'h10, d);
    cmd2(8'h35, 8'h00, d);
    chk("lockBits", d, 8'h10);
    write1(8'h42, 24'h002010, 8'h00);
    read1(8'h48, 24'h002010, d);
    chk("lockedRegion", d, 8'h34);
    erase(8'h44, 24'h001000, 256);
    read1(8'h48, 24'h001010, d);
    chk("region1Erased", d, 8'hFF);
    read1(8'h48, 24'h002010, d);
    chk("region2Kept", d, 8'h34);
    wren();
    cmd2(8'h31, 8'h00, d);
    cmd2(8'h35, 8'h00, d);
    chk("lockSticky", d, 8'h10);
  endtask : t_secreg

  // ================================================================
  // main sequence and hang guard
  initial
  begin
    resetN = 1'b0;
    repeat (10) @(posedge clk);
    resetN <= 1'b1;
    repeat (3) @(posedge clk);
    t_header();
    t_readonly();
    t_program();
    t_sector();
    t_secreg();
    closeOut();
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      nMismatch++;
      closeOut();
    end
  end
endmodule : testbench

`default_nettype wire
